/* File: bench/sdmrc_ctrl_checker.sv */
// port checker for the dac mode and reset control
// assumes it is bound onto every sdmrc_ctrl instance
module sdmrc_ctrl_checker #(
   parameter int unsigned FRAME_MIN_CYC = 1041,
   parameter int unsigned FRAME_MAX_CYC = 25000
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic audio_data,
   input wire logic mode_data,
   input wire logic sw_scheme,
   input wire sdmrc_pkg::sdmrc_cfg_t hw_cfg,
   input wire logic analogue_supply_ok,
   input wire logic digital_supply_ok,
   input wire logic midrail_reference_node_ok,
   input wire logic clock_present,
   input wire logic supply_good_reset_n,
   input wire logic filter_reset,
   input wire logic filter_bypass,
   input wire logic mute_out,
   input wire logic deemph_en,
   input wire logic [1:0] deemph_rate,
   input wire logic [7:0] att_left,
   input wire logic [7:0] att_right,
   input wire logic [7:0] mod_osr,
   input wire sdmrc_pkg::sdmrc_audio_t audio
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire all_ok = analogue_supply_ok && digital_supply_ok && midrail_reference_node_ok;

   // =====
   // supply-good reset and clock loss
   a_rise_needs_supplies: assert property (
      $rose(supply_good_reset_n) |-> $past(all_ok, 3)) else $error("ready rose early");
   a_loss_drops_ready: assert property (
      !all_ok |-> ##3 !supply_good_reset_n) else $error("ready kept after supply loss");
   a_att_forced: assert property (
      !supply_good_reset_n |=> att_left == 8'hFF && att_right == 8'hFF)
      else $error("attenuation not held at default");
   a_mute_unready: assert property (
      !supply_good_reset_n |=> mute_out && filter_reset) else $error("output live while unready");
   a_no_audio_unready: assert property (
      !supply_good_reset_n |=> !audio.valid) else $error("sample while unready");
   a_clock_loss_mutes: assert property (
      $fell(clock_present) |-> ##[2:4] (filter_reset && mute_out)) else $error("no mute on clock loss");

   // =====
   // register port and stream
   a_read_quiet: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
   a_osr_fixed: assert property (
      mod_osr == sdmrc_pkg::SDMRC_MOD_OSR) else $error("oversampling ratio wrong");
   a_valid_single: assert property (
      audio.valid |=> !audio.valid) else $error("sample strobe longer than one cycle");

   c_ready: cover property ($rose(supply_good_reset_n));
   c_sample: cover property (audio.valid && !filter_bypass);
   c_direct: cover property (audio.valid && filter_bypass);
endmodule // sdmrc_ctrl_checker

bind sdmrc_ctrl sdmrc_ctrl_checker #(
   .FRAME_MIN_CYC(FRAME_MIN_CYC), .FRAME_MAX_CYC(FRAME_MAX_CYC)) i_chk (
   .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bclk, .lrclk,
   .audio_data, .mode_data, .sw_scheme, .hw_cfg, .analogue_supply_ok, .digital_supply_ok,
   .midrail_reference_node_ok, .clock_present, .supply_good_reset_n, .filter_reset,
   .filter_bypass, .mute_out, .deemph_en, .deemph_rate, .att_left, .att_right, .mod_osr,
   .audio);

/* File: bench/sdmrc_ctrl_test.sv */
// self-checking bench for the dac mode and reset control
// assumes the source model drives the serial pins
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module sdmrc_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [10:0] w;
      logic en;
      logic [1:0] rate;
      logic byp;
      logic mu;
   } sdmrc_row_t;
   logic mclk, nrst, reg_wr, reg_rd, sw_scheme, clock_present, ana_ok, dig_ok, mid_ok;
   logic sgr_n, filter_reset, filter_bypass, mute_out, deemph_en;
   logic bclk, lrclk, audio_data, mode_data;
   logic [7:0] reg_addr, att_left, att_right, mod_osr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0] deemph_rate;
   sdmrc_pkg::sdmrc_cfg_t hw_cfg;
   sdmrc_pkg::sdmrc_audio_t audio;
   int n_mismatch = 0;
   int num_checks = 0;
   sdmrc_row_t rows [6] = '{'{11'h002, 1'b0, 2'h0, 1'b0, 1'b0}, '{11'h031, 1'b1, 2'h1, 1'b0, 1'b0},
      '{11'h056, 1'b1, 2'h2, 1'b0, 1'b0}, '{11'h08B, 1'b0, 2'h0, 1'b0, 1'b1},
      '{11'h400, 1'b0, 2'h0, 1'b1, 1'b0}, '{11'h302, 1'b0, 2'h0, 1'b0, 1'b0}};

   sdmrc_source i_sdmrc_source (.bclk, .lrclk, .data(audio_data), .mode_data);
   sdmrc_ctrl i_sdmrc_ctrl (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .bclk, .lrclk, .audio_data, .mode_data, .sw_scheme, .hw_cfg, .analogue_supply_ok(ana_ok),
      .digital_supply_ok(dig_ok), .midrail_reference_node_ok(mid_ok), .clock_present,
      .supply_good_reset_n(sgr_n), .filter_reset, .filter_bypass, .mute_out, .deemph_en,
      .deemph_rate, .att_left, .att_right, .mod_osr, .audio);

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // =====
   // bus and check tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      `CHK("rdata", e, reg_rdata)
      @(posedge mclk);
   endtask
   task automatic wait_ready();
      int i = 0;
      while (sgr_n !== 1'b1 && i < 20) begin
         @(posedge mclk);
         i++;
      end
      `CHK("ready", 1'b1, sgr_n)
   endtask
   task automatic chk_out(input logic en, input logic [1:0] rt, input logic byp, input logic mu);
      `CHK("deemph_en", en, deemph_en)
      `CHK("deemph_rate", rt, deemph_rate)
      `CHK("bypass", byp, filter_bypass)
      `CHK("mute", mu, mute_out)
   endtask
   // waits out one whole frame, bounded well above its length
   task automatic frame(input logic d8, input logic [23:0] l, input logic [23:0] r,
                        input logic [23:0] el, input logic [23:0] er);
      int i = 0;
      fork
         if (d8) i_sdmrc_source.send_d8(l, r);
         else i_sdmrc_source.send_i2s(l, r);
         while (audio.valid !== 1'b1 && i < 3000) begin
            @(posedge mclk);
            i++;
         end
      join
      @(posedge mclk);
      `CHK("valid", 1'b1, i < 3000)
      `CHK("left", el, audio.left)
      `CHK("right", er, audio.right)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #300us;
      n_mismatch++;
      report_and_stop();
   end

   // =====
   // main sequence
   initial begin
      nrst <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 32'h0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      sw_scheme <= 1'b1;
      hw_cfg <= '0;
      clock_present <= 1'b1;
      ana_ok <= 1'b0;
      dig_ok <= 1'b0;
      mid_ok <= 1'b0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      ana_ok <= 1'b1;
      mid_ok <= 1'b1;
      wr(sdmrc_pkg::SDMRC_OFS_ATT_LEFT, 32'h12);
      repeat (8) @(posedge mclk);
      `CHK("early ready", 1'b0, sgr_n)
      dig_ok <= 1'b1;
      wait_ready();
      rd_chk(sdmrc_pkg::SDMRC_OFS_ATT_LEFT, 32'hFF);
      rd_chk(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h002);
      wr(sdmrc_pkg::SDMRC_OFS_ATT_LEFT, 32'h40);
      wr(sdmrc_pkg::SDMRC_OFS_ATT_RIGHT, 32'h21);
      `CHK("att_left", 8'h40, att_left)
      `CHK("att_right", 8'h21, att_right)
      rd_chk(8'h20, 32'h0);
      foreach (rows[k]) begin
         wr(sdmrc_pkg::SDMRC_OFS_CTRL, {21'h0, rows[k].w});
         rd_chk(sdmrc_pkg::SDMRC_OFS_CTRL, {21'h0, rows[k].w});
         chk_out(rows[k].en, rows[k].rate, rows[k].byp, rows[k].mu);
      end
      // pin scheme: 32k de-emphasis and mute, seen after synchronising
      sw_scheme <= 1'b0;
      hw_cfg <= sdmrc_pkg::sdmrc_cfg_t'(11'h0D0);
      repeat (8) @(posedge mclk);
      chk_out(1'b1, 2'h2, 1'b0, 1'b1);
      sw_scheme <= 1'b1;
      wr(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h002);
      i_sdmrc_source.send_i2s(24'h0, 24'h0);
      frame(1'b0, 24'hA5C3E1, 24'h1E3C5A, 24'hA5C3E1, 24'h1E3C5A);
      rd_chk(sdmrc_pkg::SDMRC_OFS_STATUS, 32'h17);
      wr(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h000);
      frame(1'b0, 24'hA5C3E1, 24'h1E3C5A, 24'hA5C300, 24'h1E3C00);
      wr(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h302);
      frame(1'b0, 24'h123456, 24'h89ABCD, 24'h89ABCD, 24'h89ABCD);
      wr(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h082);
      frame(1'b0, 24'h7F00FF, 24'h00FF7F, 24'h0, 24'h0);
      clock_present <= 1'b0;
      repeat (6) @(posedge mclk);
      `CHK("filter_reset", 1'b1, filter_reset)
      `CHK("mute_out", 1'b1, mute_out)
      clock_present <= 1'b1;
      repeat (6) @(posedge mclk);
      `CHK("filter_reset", 1'b0, filter_reset)
      rd_chk(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h082);
      dig_ok <= 1'b0;
      repeat (6) @(posedge mclk);
      `CHK("ready", 1'b0, sgr_n)
      dig_ok <= 1'b1;
      wait_ready();
      rd_chk(sdmrc_pkg::SDMRC_OFS_ATT_RIGHT, 32'hFF);
      wr(sdmrc_pkg::SDMRC_OFS_CTRL, 32'h402);
      @(posedge mclk);
      `CHK("bypass", 1'b1, filter_bypass)
      frame(1'b1, 24'hC0FFEE, 24'h5A5A0F, 24'hC0FFEE, 24'h5A5A0F);
      report_and_stop();
   end
endmodule // sdmrc_ctrl_test

/* File: bench/sdmrc_source.sv */
// audio source model: bit clock, word clock, data and mode data lines
// assumes 125 ns bit clock; the bit clock stands low between frames
module sdmrc_source (
   output logic bclk,
   output logic lrclk,
   output logic data,
   output logic mode_data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      bclk = 1'b0;
      lrclk = 1'b1;
      data = 1'b0;
      mode_data = 1'b1;
   end

   // lines change only while the bit clock is low
   task automatic bit_out(input logic d, input logic m);
      data = d;
      mode_data = m;
      #62.5 bclk = 1'b1;
      #62.5 bclk = 1'b0;
   endtask

   task automatic word(input logic [23:0] w, input logic [23:0] m);
      for (int i = 23; i >= 0; i--) begin
         bit_out(w[i], m[i]);
      end
   endtask

   // closing fall doubles as the next delay bit, so no fall is repeated
   task automatic send_i2s(input logic [23:0] l, input logic [23:0] r);
      if (lrclk) begin
         lrclk = 1'b0;
         bit_out(~data, ~mode_data);
      end
      word(l, ~l);
      lrclk = 1'b1;
      bit_out(~data, ~mode_data);
      word(r, ~r);
      lrclk = 1'b0;
      bit_out(~data, ~mode_data);
      data = ~data;
   endtask

   // right word on the mode line, slow rate only
   task automatic send_d8(input logic [23:0] l, input logic [23:0] r);
      lrclk = 1'b0;
      word(l, r);
      lrclk = 1'b1;
      bit_out(~data, ~mode_data);
      data = ~data;
      mode_data = ~mode_data;
   endtask
endmodule // sdmrc_source

/* File: core/sdmrc_ctrl.sv */
// mode, format and supply-good reset control of a stereo sigma-delta dac
// assumes all pins are asynchronous to mclk and bclk is well below mclk/4
//
// Operation
// - on supply-good release every setting holds its default and writes are taken
// - control writes before ready are discarded and change nothing
// - logic held in reset while any supply or midrail is not good
// - midrail alone never releases reset; digital supply must be good too
// - settings come from hardware pins or software registers per selected scheme
// - word length 16 to 24 bits; i2s, left or right justified
// - de-emphasis rate selects 48, 44.1 or 32 kHz
// - mute from pin or software; attenuation held per channel
// - direct 8x mode passes samples to modulator bypassing all filters
// - in direct 8x mode the mode pin carries right channel data
// - dual differential converts one selected channel onto both outputs
// - dual differential works in both schemes and with direct 8x
// - modulator runs at 128 fs with 64 quantisation levels
// - sample rates from 8 to 192 thousand per second accepted
// - audio words arrive most significant bit first
// - lost clock resets filters and mutes, settings kept, restart initialised
module sdmrc_ctrl #(
   parameter int unsigned FRAME_MIN_CYC = sdmrc_pkg::SDMRC_FRAME_MIN_CYC,
   parameter int unsigned FRAME_MAX_CYC = sdmrc_pkg::SDMRC_FRAME_MAX_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [sdmrc_pkg::SDMRC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic audio_data,
   input wire logic mode_data,
   input wire logic sw_scheme,
   input wire sdmrc_pkg::sdmrc_cfg_t hw_cfg,
   input wire logic analogue_supply_ok,
   input wire logic digital_supply_ok,
   input wire logic midrail_reference_node_ok,
   input wire logic clock_present,
   output logic supply_good_reset_n,
   output logic filter_reset,
   output logic filter_bypass,
   output logic mute_out,
   output logic deemph_en,
   output logic [1:0] deemph_rate,
   output logic [7:0] att_left,
   output logic [7:0] att_right,
   output logic [7:0] mod_osr,
   output sdmrc_pkg::sdmrc_audio_t audio
);

   typedef struct packed {
      logic por_ok;
      logic clk_ok;
      sdmrc_pkg::sdmrc_cfg_t cfg;
      logic [7:0] att_l;
      logic [7:0] att_r;
      logic bclk_prev;
      logic lr_prev;
      logic lr_frame_prev;
      logic [4:0] bitcnt;
      logic [23:0] acc_l;
      logic [23:0] acc_r;
      logic [23:0] held_left;
      logic [sdmrc_pkg::SDMRC_FRAME_CNT_W-1:0] frame_cnt;
      logic rate_ok;
      sdmrc_pkg::sdmrc_audio_t audio;
      logic [31:0] rdata;
      logic filter_reset;
      logic filter_bypass;
      logic mute;
      logic deemph_en;
      logic [1:0] deemph_rate;
      logic [7:0] mod_osr;
   } sdmrc_state_t;

   sdmrc_state_t state_reg;
   sdmrc_state_t state_next;
   sdmrc_pkg::sdmrc_pins_t pins_raw;
   sdmrc_pkg::sdmrc_pins_t pins;

   // ==========================================================
   // pin synchronisers
   always_comb begin
      pins_raw.bclk = bclk;
      pins_raw.lrclk = lrclk;
      pins_raw.data = audio_data;
      pins_raw.mode_data = mode_data;
      pins_raw.sw_scheme = sw_scheme;
      pins_raw.hw = hw_cfg;
      pins_raw.analogue_ok = analogue_supply_ok;
      pins_raw.digital_ok = digital_supply_ok;
      pins_raw.midrail_ok = midrail_reference_node_ok;
      pins_raw.clock_present = clock_present;
   end

   // bits synchronised singly; a multi-pin change may land over two edges
   // two-flop pin sync
   sdmrc_sync #(
      .W($bits(sdmrc_pkg::sdmrc_pins_t))
   ) u_pin_sync (
      .mclk(mclk),
      .nrst(nrst),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   function automatic logic [4:0] word_bits(input logic [1:0] code);
      logic [4:0] n;
      n = 5'h18;
      case (code)
         sdmrc_pkg::SDMRC_WL_16: n = 5'h10;
         sdmrc_pkg::SDMRC_WL_18: n = 5'h12;
         sdmrc_pkg::SDMRC_WL_20: n = 5'h14;
         default: n = 5'h18;
      endcase
      return n;
   endfunction

   // ==========================================================
   // next state
   sdmrc_pkg::sdmrc_cfg_t eff;
   logic por_now;
   logic active;
   logic bclk_rise;
   logic boundary;
   logic lr_rise;
   logic take;
   logic is_left_word;
   logic [4:0] wb;
   logic [4:0] shamt;
   logic skip;
   logic [23:0] word_l;
   logic [23:0] word_r;
   logic [23:0] out_l;
   logic [23:0] out_r;
   logic cap_pair;

   always_comb begin
      state_next = state_reg;
      state_next.audio.valid = 1'b0;
      // read data stands one cycle, zero otherwise
      state_next.rdata = 32'h0000_0000;
      por_now = pins.analogue_ok & pins.digital_ok & pins.midrail_ok;
      state_next.por_ok = por_now;
      state_next.clk_ok = pins.clock_present;
      // receiver runs only with supplies good and clock seen
      active = state_reg.por_ok & state_reg.clk_ok;

      eff = pins.sw_scheme ? state_reg.cfg : pins.hw;
      // dual diff taken from either scheme
      eff.dual_diff = pins.sw_scheme ? state_reg.cfg.dual_diff : pins.hw.dual_diff;

      // ------------------------------------------------------
      // register port
      if (reg_wr && state_reg.por_ok) begin
         case (reg_addr)
            sdmrc_pkg::SDMRC_OFS_CTRL: begin
               state_next.cfg = reg_wdata[$bits(sdmrc_pkg::sdmrc_cfg_t)-1:0];
            end
            sdmrc_pkg::SDMRC_OFS_ATT_LEFT: begin
               state_next.att_l = reg_wdata[7:0];
            end
            sdmrc_pkg::SDMRC_OFS_ATT_RIGHT: begin
               state_next.att_r = reg_wdata[7:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            sdmrc_pkg::SDMRC_OFS_CTRL: begin
               state_next.rdata = {21'h000000, state_reg.cfg};
            end
            sdmrc_pkg::SDMRC_OFS_ATT_LEFT: begin
               state_next.rdata = {24'h000000, state_reg.att_l};
            end
            sdmrc_pkg::SDMRC_OFS_ATT_RIGHT: begin
               state_next.rdata = {24'h000000, state_reg.att_r};
            end
            sdmrc_pkg::SDMRC_OFS_STATUS: begin
               state_next.rdata = {26'h0000000, state_reg.filter_bypass, state_reg.rate_ok,
                  state_reg.mute, pins.sw_scheme, state_reg.clk_ok, state_reg.por_ok};
            end
            default: begin
               state_next.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (!state_reg.por_ok) begin
         state_next.cfg = sdmrc_pkg::SDMRC_CFG_RESET;
         state_next.att_l = sdmrc_pkg::SDMRC_ATT_RESET;
         state_next.att_r = sdmrc_pkg::SDMRC_ATT_RESET;
      end

      // ------------------------------------------------------
      // serial receiver, sampled on detected bclk rise
      wb = word_bits(eff.word_len);
      shamt = 5'h18 - wb;
      // i2s words start one bit late
      skip = (eff.fmt == sdmrc_pkg::SDMRC_FMT_I2S) && !eff.direct8x;
      bclk_rise = pins.bclk & ~state_reg.bclk_prev;
      boundary = pins.lrclk ^ state_reg.lr_prev;
      is_left_word = (eff.fmt == sdmrc_pkg::SDMRC_FMT_I2S) ? ~state_reg.lr_prev
         : state_reg.lr_prev;
      word_l = state_reg.acc_l << shamt;
      word_r = state_reg.acc_r << shamt;
      cap_pair = 1'b0;
      take = 1'b0;
      state_next.bclk_prev = pins.bclk;
      if (bclk_rise) begin
         state_next.lr_prev = pins.lrclk;
         if (boundary) begin
            if (eff.direct8x) begin
               if (pins.lrclk) begin
                  cap_pair = 1'b1;
               end
            end else if (is_left_word) begin
               state_next.held_left = word_l;
            end else begin
               word_r = word_l;
               word_l = state_reg.held_left;
               cap_pair = 1'b1;
            end
            take = eff.direct8x || (eff.fmt == sdmrc_pkg::SDMRC_FMT_RIGHT) || !skip;
            state_next.bitcnt = 5'h01;
            state_next.acc_l = take ? {23'h000000, pins.data} : 24'h000000;
            state_next.acc_r = take ? {23'h000000, pins.mode_data} : 24'h000000;
         end else begin
            // sticks at the top so an overlong word cannot wrap
            if (state_reg.bitcnt != 5'h1F) begin
               state_next.bitcnt = state_reg.bitcnt + 5'h01;
            end
            // right justified shifts all, so only the last wl bits survive
            take = eff.direct8x || (eff.fmt == sdmrc_pkg::SDMRC_FMT_RIGHT)
               || (({1'b0, state_reg.bitcnt} >= {5'h00, skip})
               && ({1'b0, state_reg.bitcnt} < ({1'b0, wb} + {5'h00, skip})));
            if (take) begin
               state_next.acc_l = {state_reg.acc_l[22:0], pins.data};
               state_next.acc_r = {state_reg.acc_r[22:0], pins.mode_data};
            end
         end
      end

      out_l = word_l;
      out_r = word_r;
      if (eff.dual_diff) begin
         out_l = eff.diff_right ? word_r : word_l;
         out_r = out_l;
      end
      // registered mute used, so a mute change lags one edge
      if (cap_pair && active) begin
         state_next.audio.left = state_next.mute ? 24'h000000 : out_l;
         state_next.audio.right = state_next.mute ? 24'h000000 : out_r;
         state_next.audio.valid = 1'b1;
      end

      // ------------------------------------------------------
      // frame period range check
      // counter saturates so a stopped word clock reads as too slow at its next rise
      lr_rise = pins.lrclk & ~state_reg.lr_frame_prev;
      state_next.lr_frame_prev = pins.lrclk;
      if (lr_rise) begin
         state_next.frame_cnt = '0;
         state_next.rate_ok = (32'(state_reg.frame_cnt) >= FRAME_MIN_CYC - 32'd1)
            && (32'(state_reg.frame_cnt) < FRAME_MAX_CYC);
      end else if (state_reg.frame_cnt != '1) begin
         state_next.frame_cnt = state_reg.frame_cnt + sdmrc_pkg::SDMRC_FRAME_CNT_W'(1);
      end

      // ------------------------------------------------------
      // mode outputs
      // lost clock resets filters and mutes, cfg kept
      state_next.filter_reset = ~active;
      state_next.mute = eff.mute | ~active;
      state_next.filter_bypass = eff.direct8x;
      state_next.deemph_en = eff.deemph_en;
      case (eff.deemph_rate)
         sdmrc_pkg::SDMRC_DE_44K1: state_next.deemph_rate = sdmrc_pkg::SDMRC_DE_44K1;
         sdmrc_pkg::SDMRC_DE_32K: state_next.deemph_rate = sdmrc_pkg::SDMRC_DE_32K;
         default: state_next.deemph_rate = sdmrc_pkg::SDMRC_DE_48K;
      endcase
      state_next.mod_osr = sdmrc_pkg::SDMRC_MOD_OSR;

      // receiver restarts clean after clock loss
      if (!active) begin
         state_next.acc_l = 24'h000000;
         state_next.acc_r = 24'h000000;
         state_next.bitcnt = 5'h00;
         state_next.held_left = 24'h000000;
      end
   end

   // ==========================================================
   // flops; cfg survives clock loss, only supply-good reset or nrst clears it
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
         state_reg.cfg <= sdmrc_pkg::SDMRC_CFG_RESET;
         state_reg.att_l <= sdmrc_pkg::SDMRC_ATT_RESET;
         state_reg.att_r <= sdmrc_pkg::SDMRC_ATT_RESET;
         state_reg.filter_reset <= 1'b1;
         state_reg.mute <= 1'b1;
         state_reg.mod_osr <= sdmrc_pkg::SDMRC_MOD_OSR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata = state_reg.rdata;
   assign supply_good_reset_n = state_reg.por_ok;
   assign filter_reset = state_reg.filter_reset;
   assign filter_bypass = state_reg.filter_bypass;
   assign mute_out = state_reg.mute;
   assign deemph_en = state_reg.deemph_en;
   assign deemph_rate = state_reg.deemph_rate;
   assign att_left = state_reg.att_l;
   assign att_right = state_reg.att_r;
   assign mod_osr = state_reg.mod_osr;
   // audio words left aligned in 24 bits
   assign audio = state_reg.audio;

endmodule // sdmrc_ctrl

/* File: core/sdmrc_pkg.sv */
// constants, field layouts and carrier types for the dac mode and reset control
// assumes a 200 MHz mclk and a plain strobe register port
package sdmrc_pkg;

   // ==========================================================
   // clock and rates
   localparam int unsigned SDMRC_MCLK_HZ = 200_000_000;
   localparam int unsigned SDMRC_MIN_FS_HZ = 8_000;
   localparam int unsigned SDMRC_MAX_FS_HZ = 192_000;
   localparam int unsigned SDMRC_FRAME_MIN_CYC = SDMRC_MCLK_HZ / SDMRC_MAX_FS_HZ;
   localparam int unsigned SDMRC_FRAME_MAX_CYC = SDMRC_MCLK_HZ / SDMRC_MIN_FS_HZ;
   localparam int SDMRC_FRAME_CNT_W = 16;
   localparam logic [7:0] SDMRC_MOD_OSR = 8'h80;
   localparam logic [6:0] SDMRC_MOD_LEVELS = 7'h40;

   // ==========================================================
   // register map
   localparam int SDMRC_ADDR_W = 8;
   localparam logic [7:0] SDMRC_OFS_CTRL = 8'h00;
   localparam logic [7:0] SDMRC_OFS_ATT_LEFT = 8'h04;
   localparam logic [7:0] SDMRC_OFS_ATT_RIGHT = 8'h08;
   localparam logic [7:0] SDMRC_OFS_STATUS = 8'h0C;

   // ==========================================================
   // field codes
   localparam logic [1:0] SDMRC_WL_16 = 2'h0;
   localparam logic [1:0] SDMRC_WL_20 = 2'h1;
   localparam logic [1:0] SDMRC_WL_24 = 2'h2;
   localparam logic [1:0] SDMRC_WL_18 = 2'h3;
   localparam logic [1:0] SDMRC_FMT_I2S = 2'h0;
   localparam logic [1:0] SDMRC_FMT_LEFT = 2'h1;
   localparam logic [1:0] SDMRC_FMT_RIGHT = 2'h2;
   localparam logic [1:0] SDMRC_DE_48K = 2'h0;
   localparam logic [1:0] SDMRC_DE_44K1 = 2'h1;
   localparam logic [1:0] SDMRC_DE_32K = 2'h2;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic direct8x;
      logic diff_right;
      logic dual_diff;
      logic mute;
      logic [1:0] deemph_rate;
      logic deemph_en;
      logic [1:0] fmt;
      logic [1:0] word_len;
   } sdmrc_cfg_t;

   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
      logic valid;
   } sdmrc_audio_t;

   typedef struct packed {
      logic bclk;
      logic lrclk;
      logic data;
      logic mode_data;
      logic sw_scheme;
      sdmrc_cfg_t hw;
      logic analogue_ok;
      logic digital_ok;
      logic midrail_ok;
      logic clock_present;
   } sdmrc_pins_t;

   // ==========================================================
   // reset values
   localparam sdmrc_cfg_t SDMRC_CFG_RESET = '{
      direct8x: 1'b0, diff_right: 1'b0, dual_diff: 1'b0, mute: 1'b0,
      deemph_rate: SDMRC_DE_48K, deemph_en: 1'b0, fmt: SDMRC_FMT_I2S,
      word_len: SDMRC_WL_24};
   localparam logic [7:0] SDMRC_ATT_RESET = 8'hFF;

endpackage

/* File: core/sdmrc_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is an independent level; no word coherence is given
module sdmrc_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sdmrc_sync_state_t;

   sdmrc_sync_state_t state_reg;
   sdmrc_sync_state_t state_next;

   // ==========================================================
   // flops
   always_comb begin
      state_next.stage1 = async_in;
      state_next.stage2 = state_reg.stage1;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stage2;

endmodule // sdmrc_sync
